/* File: emda_top.v */
// memory debug access and ecc write path with wishbone slave
// assumes a single-port memory array answering in one cycle, synchronous inputs
// Functional notes
// - command register always readable; writes accepted only in special mode.
// - bit 7 set disables automatic single-bit repair on reads.
// - write command bit 1 stores debug data and check raw at pointer.
// - write command bit clears itself when the debug write finishes.
// - read command bit 0 starts raw read at pointer.
// - read done clears bit, loads raw data and raw check value.
// - writing zero to command bits changes nothing.
// - both commands set together: only write command set and performed.
// - setting a command is refused while one is still pending.
// - memory takes 1-4 byte writes; check values per aligned 16-bit word.
// - whole-word writes take two back-to-back access cycles, one per 16-bit half, with fresh check values.
`timescale 1ns/10ps
`include "emda_defs.vh"
module emda_top #(
  parameter AW = 12
) (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire                 special_mode_i,
  // register slave
  input  wire                 wb_cyc_i,
  input  wire                 wb_stb_i,
  input  wire                 wb_we_i,
  input  wire [5:0]           wb_adr_i,
  input  wire [3:0]           wb_sel_i,
  input  wire [31:0]          wb_dat_i,
  output reg  [31:0]          wb_dat_o,
  output reg                  wb_ack_o,
  // system bus write port, 32-bit aligned
  input  wire                 sys_wr_i,
  input  wire [AW-2:0]        sys_adr_i,
  input  wire [3:0]           sys_sel_i,
  input  wire [31:0]          sys_dat_i,
  output reg                  sys_busy_o,
  output reg                  sys_done_o,
  // memory array, one 16-bit word plus check
  output reg                  mem_en_o,
  output reg                  mem_we_o,
  output reg  [AW-1:0]        mem_adr_o,
  output reg  [`EMDA_DW-1:0]  mem_dat_o,
  output reg  [`EMDA_CW-1:0]  mem_chk_o,
  input  wire [`EMDA_DW-1:0]  mem_dat_i,
  input  wire [`EMDA_CW-1:0]  mem_chk_i,
  output reg                  read_repair_disable_o
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_WLO   = 7'h02;
  localparam [6:0] S_WHI   = 7'h04;
  localparam [6:0] S_RMW_R = 7'h08;
  localparam [6:0] S_RMW_W = 7'h10;
  localparam [6:0] S_DRD   = 7'h20;
  localparam [6:0] S_DRD_C = 7'h40;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam BW = 8;
  localparam HW = `EMDA_DW / BW;

  reg  [6:0]          state;
  reg  [7:0]          ecc_debug_command;
  reg  [7:0]          next_cmd;
  reg  [AW-1:0]       debug_address_pointer;
  reg  [`EMDA_DW-1:0] debug_data_word;
  reg  [`EMDA_CW-1:0] debug_check_value;
  reg  [AW-2:0]       lat_adr;
  reg  [3:0]          lat_sel;
  reg  [31:0]         lat_dat;
  reg                 half;
  reg  [31:0]         next_wb_dat;
  wire [`EMDA_DW-1:0] merged;
  wire [`EMDA_CW-1:0] gen_chk;
  reg  [`EMDA_DW-1:0] gen_in;

  wire debug_write_cmd = ecc_debug_command[`EMDA_BIT_WR];
  wire debug_read_cmd  = ecc_debug_command[`EMDA_BIT_RD];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire hit_cmd   = (wb_adr_i == `EMDA_ADR_CMD);
  wire hit_ptr   = (wb_adr_i == `EMDA_ADR_PTR);
  wire hit_data  = (wb_adr_i == `EMDA_ADR_DATA);
  wire hit_check = (wb_adr_i == `EMDA_ADR_CHECK);
  wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr     = wb_req & wb_we_i;
  // only byte lane 0 carries command bits
  wire cmd_wr    = wb_wr & hit_cmd & wb_sel_i[0] & special_mode_i;
  // a new command is accepted only when both bits are clear
  wire cmd_free  = ~debug_write_cmd & ~debug_read_cmd;

  // ----------------------------------------
  // halfword helpers
  // ----------------------------------------
  wire [1:0] lat_half_sel = half ? lat_sel[3:2] : lat_sel[1:0];
  wire [15:0] lat_half_dat = half ? lat_dat[31:16] : lat_dat[15:0];
  wire half_full  = &lat_half_sel;
  // upper halfword still owed after the current one
  wire hi_pending = ~half & (|lat_sel[3:2]);

  // old bytes kept where the lane is not enabled
  genvar b;
  generate
    for (b = 0; b < HW; b = b + 1) begin : gen_merge
      assign merged[BW*b +: BW] = lat_half_sel[b] ? lat_half_dat[BW*b +: BW] : mem_dat_i[BW*b +: BW];
    end
  endgenerate

  always @* begin
    gen_in = lat_half_dat;
    if (state == S_RMW_W)
      gen_in = merged;
  end

  // check value per aligned 16-bit word
  emda_check_gen u_gen (
    .data_i  (gen_in),
    .check_o (gen_chk)
  );

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always @* begin
    case (wb_adr_i)
      `EMDA_ADR_CMD:   next_wb_dat = {24'h000000, ecc_debug_command};
      `EMDA_ADR_PTR:   next_wb_dat = {{(32-AW){1'b0}}, debug_address_pointer};
      `EMDA_ADR_DATA:  next_wb_dat = {16'h0000, debug_data_word};
      `EMDA_ADR_CHECK: next_wb_dat = {26'h0000000, debug_check_value};
      `EMDA_ADR_MODE:  next_wb_dat = {31'h00000000, special_mode_i};
      default:         next_wb_dat = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // wishbone register slave
  // ----------------------------------------
  // ack answers one cycle after the request; read data is registered too
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= next_wb_dat;
    end
  end

  // ----------------------------------------
  // pointer and repair control
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      debug_address_pointer <= {AW{1'b0}};
      read_repair_disable_o <= 1'b0;
    end else begin
      if (wb_wr && hit_ptr)
        debug_address_pointer <= wb_dat_i[AW-1:0];
      if (cmd_wr)
        read_repair_disable_o <= wb_dat_i[`EMDA_BIT_RRD];
    end
  end

  // ----------------------------------------
  // command register next value
  // ----------------------------------------
  // zero bits leave pending work alone; write beats read
  always @* begin
    next_cmd = ecc_debug_command;
    if (cmd_wr)
      next_cmd[`EMDA_BIT_RRD] = wb_dat_i[`EMDA_BIT_RRD];
    if (cmd_wr && cmd_free) begin
      if (wb_dat_i[`EMDA_BIT_WR])
        next_cmd[`EMDA_BIT_WR] = 1'b1;
      else if (wb_dat_i[`EMDA_BIT_RD])
        next_cmd[`EMDA_BIT_RD] = 1'b1;
    end
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  // debug data regs written by software only while no debug read is pending
  always @(posedge clk_i) begin
    if (rst_i) begin
      state             <= S_IDLE;
      ecc_debug_command <= `EMDA_CMD_RESET;
      debug_data_word   <= {`EMDA_DW{1'b0}};
      debug_check_value <= {`EMDA_CW{1'b0}};
      lat_adr           <= {(AW-1){1'b0}};
      lat_sel           <= 4'h0;
      lat_dat           <= 32'h0000_0000;
      half              <= 1'b0;
      sys_busy_o        <= 1'b0;
      sys_done_o        <= 1'b0;
      mem_en_o          <= 1'b0;
      mem_we_o          <= 1'b0;
      mem_adr_o         <= {AW{1'b0}};
      mem_dat_o         <= {`EMDA_DW{1'b0}};
      mem_chk_o         <= {`EMDA_CW{1'b0}};
    end else begin
      // strobes are single-cycle pulses unless a state raises them
      mem_en_o   <= 1'b0;
      mem_we_o   <= 1'b0;
      sys_done_o <= 1'b0;
      // clears below only hit a set bit, which blocks any new set
      ecc_debug_command <= next_cmd;
      if (wb_wr && hit_data && !debug_read_cmd)
        debug_data_word <= wb_dat_i[`EMDA_DW-1:0];
      if (wb_wr && hit_check && !debug_read_cmd)
        debug_check_value <= wb_dat_i[`EMDA_CW-1:0];

      case (state)
        S_IDLE: begin
          if (debug_write_cmd) begin
            // raw store, no check regeneration
            mem_en_o   <= 1'b1;
            mem_we_o   <= 1'b1;
            mem_adr_o  <= debug_address_pointer;
            mem_dat_o  <= debug_data_word;
            mem_chk_o  <= debug_check_value;
            ecc_debug_command[`EMDA_BIT_WR] <= 1'b0;
          end else if (debug_read_cmd) begin
            mem_en_o  <= 1'b1;
            mem_adr_o <= debug_address_pointer;
            state     <= S_DRD;
          end else if (sys_wr_i && |sys_sel_i) begin
            // debug commands win over system writes
            lat_adr    <= sys_adr_i;
            lat_sel    <= sys_sel_i;
            lat_dat    <= sys_dat_i;
            half       <= ~|sys_sel_i[1:0];
            sys_busy_o <= 1'b1;
            state      <= S_WLO;
          end
        end
        S_WLO, S_WHI: begin
          mem_adr_o <= {lat_adr, half};
          if (half_full) begin
            // one cycle store with fresh check
            mem_en_o  <= 1'b1;
            mem_we_o  <= 1'b1;
            mem_dat_o <= lat_half_dat;
            mem_chk_o <= gen_chk;
            if (hi_pending)
              half <= 1'b1;
            else begin
              sys_busy_o <= 1'b0;
              sys_done_o <= 1'b1;
              state      <= S_IDLE;
            end
          end else begin
            // partial word needs old contents first
            mem_en_o <= 1'b1;
            state    <= S_RMW_R;
          end
        end
        S_RMW_R: begin
          // array answers one cycle after enable
          state <= S_RMW_W;
        end
        S_RMW_W: begin
          mem_en_o  <= 1'b1;
          mem_we_o  <= 1'b1;
          mem_dat_o <= merged;
          mem_chk_o <= gen_chk;
          if (hi_pending) begin
            half  <= 1'b1;
            state <= S_WHI;
          end else begin
            sys_busy_o <= 1'b0;
            sys_done_o <= 1'b1;
            state      <= S_IDLE;
          end
        end
        S_DRD: begin
          state <= S_DRD_C;
        end
        S_DRD_C: begin
          // uncorrected data, raw check
          debug_data_word   <= mem_dat_i;
          debug_check_value <= mem_chk_i;
          ecc_debug_command[`EMDA_BIT_RD] <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // emda_top

/* File: emda_defs.vh */
// constants for the memory debug access block
// assumes inclusion by the design files only
`ifndef EMDA_DEFS_VH
`define EMDA_DEFS_VH
// ----------------------------------------
// register byte addresses (wishbone)
// ----------------------------------------
`define EMDA_ADR_CMD      6'h00
`define EMDA_ADR_PTR      6'h04
`define EMDA_ADR_DATA     6'h08
`define EMDA_ADR_CHECK    6'h0c
`define EMDA_ADR_MODE     6'h10
// ----------------------------------------
// command register fields
// ----------------------------------------
`define EMDA_BIT_RD       0
`define EMDA_BIT_WR       1
`define EMDA_BIT_RRD      7
`define EMDA_CMD_RESET    8'h00
// ----------------------------------------
// memory word layout
// ----------------------------------------
`define EMDA_DW           16
`define EMDA_CW           6
`endif

/* File: emda_check_gen.v */
// check value generator for one 16-bit data word
// assumes a combinational use inside the debug access top
`timescale 1ns/10ps
`include "emda_defs.vh"
module emda_check_gen (
  input  wire [`EMDA_DW-1:0] data_i,
  output wire [`EMDA_CW-1:0] check_o
);
  // ----------------------------------------
  // hamming style parity, plus overall parity
  // ----------------------------------------
  // simple secded code; bit masks chosen per check bit
  wire [`EMDA_DW-1:0] mask [0:`EMDA_CW-2];
  assign mask[0] = 16'had5b;
  assign mask[1] = 16'h366d;
  assign mask[2] = 16'hc78e;
  assign mask[3] = 16'h07f0;
  assign mask[4] = 16'hf800;
  genvar g;
  generate
    for (g = 0; g < `EMDA_CW-1; g = g + 1) begin : gen_par
      assign check_o[g] = ^(data_i & mask[g]);
    end
  endgenerate
  assign check_o[`EMDA_CW-1] = ^{data_i, check_o[`EMDA_CW-2:0]};
endmodule // emda_check_gen

/* File: emda_mem_model.sv */
// one-cycle memory array model holding data and check bits
// assumes a single clock shared with emda_top
`timescale 1ns/10ps
module emda_mem_model #(
  parameter AW = 6
) (
  input  wire          clk_i,
  input  wire          en_i,
  input  wire          we_i,
  input  wire [AW-1:0] adr_i,
  input  wire [15:0]   dat_i,
  input  wire [5:0]    chk_i,
  output logic [15:0]  dat_o = 16'h0000,
  output logic [5:0]   chk_o = 6'h00
);
  logic [15:0] mem [0:(1<<AW)-1];
  logic [5:0]  chk [0:(1<<AW)-1];
  initial for (int i = 0; i < (1 << AW); i++) begin
    mem[i] = 16'h0000;
    chk[i] = 6'h00;
  end
  // outside a read the lines toggle, so a sample taken two cycles after a lone read comes back inverted
  always @(posedge clk_i) begin
    if (en_i && we_i) begin
      mem[adr_i] <= dat_i;
      chk[adr_i] <= chk_i;
    end
    if (en_i && !we_i) begin
      dat_o <= mem[adr_i];
      chk_o <= chk[adr_i];
    end else begin
      dat_o <= ~dat_o;
      chk_o <= ~chk_o;
    end
  end
endmodule // emda_mem_model

/* File: emda_checker.sv */
// assertions on the ports of emda_top
// assumes binding onto every emda_top instance
`timescale 1ns/10ps
module emda_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        special_mode_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [5:0]  wb_adr_i,
  input wire [3:0]  sys_sel_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        sys_busy_o,
  input wire        sys_done_o,
  input wire        mem_en_o,
  input wire        mem_we_o,
  input wire        read_repair_disable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; $rose(sys_busy_o); endsequence
  sequence s_mwr; mem_en_o && mem_we_o; endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_done_pulse: assert property (sys_done_o |=> !sys_done_o) else $error("done held");
  a_done_bound: assert property (s_start |-> ##[1:7] sys_done_o) else $error("write hung");
  a_whole_words: assert property (s_start ##0 sys_sel_i == 4'hf |-> ##[1:2] s_mwr ##1 s_mwr)
    else $error("word writes");
  a_partial_read: assert property (s_start ##0 sys_sel_i == 4'h1 |-> ##[0:3] (mem_en_o && !mem_we_o))
    else $error("no merge read");
  // the lock needs a few cycles so a write taken in special mode may land
  a_rrd_locked: assert property ((!special_mode_i) [*4] |-> $stable(read_repair_disable_o))
    else $error("repair bit moved");
  a_mode_read: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 6'h10)
    |-> wb_dat_o[0] == $past(special_mode_i)) else $error("mode read");
endmodule // emda_checker
bind emda_top emda_checker u_emda_checker (.clk_i, .rst_i, .special_mode_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .sys_sel_i, .wb_dat_o, .wb_ack_o, .sys_busy_o, .sys_done_o, .mem_en_o, .mem_we_o,
  .read_repair_disable_o);

/* File: tb_top.sv */
// self-checking bench for emda_top with a memory model
// assumes emda_mem_model and the bound checker are compiled first
`timescale 1ns/10ps
module tb_top;
  logic        clk_i = 0, rst_i = 1, mode = 0, cyc = 0, we = 0, swr = 0;
  logic [5:0]  adr = 0, p;
  logic [3:0]  sel = 0, ssel = 0;
  logic [4:0]  sadr = 0;
  logic [31:0] wdat = 0, sdat = 0, rd, old, e;
  logic [15:0] d;
  logic [5:0]  c;
  logic [11:0] oc;
  logic [3:0]  sels [9] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8, 4'h7, 4'he};
  wire [31:0]  wb_dat_o;
  wire         ack, busy, done, en, mwe, rrd;
  wire [5:0]   madr, mc, mqc;
  wire [15:0]  md, mq;
  int          seed = 1, errors = 0, cmp_count = 0, n;
  emda_top #(.AW(6)) u_emda_top (.clk_i, .rst_i, .special_mode_i(mode), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o(ack),
    .sys_wr_i(swr), .sys_adr_i(sadr), .sys_sel_i(ssel), .sys_dat_i(sdat), .sys_busy_o(busy),
    .sys_done_o(done), .mem_en_o(en), .mem_we_o(mwe), .mem_adr_o(madr), .mem_dat_o(md),
    .mem_chk_o(mc), .mem_dat_i(mq), .mem_chk_i(mqc), .read_repair_disable_o(rrd));
  emda_mem_model u_emda_mem_model (.clk_i, .en_i(en), .we_i(mwe), .adr_i(madr), .dat_i(md), .chk_i(mc),
    .dat_o(mq), .chk_o(mqc));
  always #4 clk_i = ~clk_i;
  task automatic wbx(input logic w, input logic [5:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; sel <= 4'hf; wdat <= v;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    rd = wb_dat_o;
    cyc <= 0; we <= 0;
    if (k >= 50) errors++;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
  endtask
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = v[8*i +: 8];
    return o;
  endfunction
  function automatic logic [5:0] exp_check(input logic [15:0] v);
    logic [15:0] m [5] = '{16'had5b, 16'h366d, 16'hc78e, 16'h07f0, 16'hf800};
    logic [5:0]  r;
    r = 6'h00;
    for (int i = 0; i < 5; i++) r[i] = ^(v & m[i]);
    r[5] = ^{v, r[4:0]};
    return r;
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under 2000 cycles
  initial begin repeat (5000) @(posedge clk_i); errors++; complete_run; end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    wbx(0, 6'h00, 0); chk("cmd", 32'h0, rd);
    wbx(1, 6'h00, 32'h80); wbx(0, 6'h00, 0); chk("cmd", 32'h0, rd);
    wbx(0, 6'h10, 0); chk("mode", 32'h0, rd);
    wbx(0, 6'h14, 0); chk("unmapped", 32'h0, rd);
    $display("test normal_mode done");
    mode <= 1;
    wbx(1, 6'h00, 32'h80); wbx(0, 6'h00, 0); chk("cmd", 32'h80, rd);
    chk("rrd", 32'h1, {31'h0, rrd});
    wbx(1, 6'h00, 32'h0); wbx(0, 6'h00, 0); chk("rrd", 32'h0, {31'h0, rrd});
    wbx(0, 6'h10, 0); chk("mode", 32'h1, rd);
    $display("test repair_bit done");
    for (int i = 0; i < 4; i++) begin
      p = $random(seed); d = $random(seed); c = $random(seed);
      wbx(1, 6'h04, p); wbx(1, 6'h08, d); wbx(1, 6'h0c, c);
      wbx(1, 6'h00, i == 0 ? 32'h3 : 32'h2); wbx(0, 6'h00, 0); chk("cmd", 32'h0, rd);
      chk("mem data", d, u_emda_mem_model.mem[p]);
      chk("mem check", c, u_emda_mem_model.chk[p]);
      wbx(1, 6'h08, ~d); wbx(1, 6'h00, 32'h1);
      repeat (3) @(posedge clk_i);
      wbx(0, 6'h00, 0); chk("cmd", 32'h0, rd);
      wbx(0, 6'h08, 0); chk("data", d, rd);
      wbx(0, 6'h0c, 0); chk("check", c, rd);
    end
    $display("test debug_access done");
    for (int i = 0; i < 18; i++) begin
      @(posedge clk_i);
      sadr <= $random(seed); sdat <= $random(seed); ssel <= sels[i % 9]; swr <= 1;
      @(posedge clk_i);
      old = {u_emda_mem_model.mem[{sadr, 1'b1}], u_emda_mem_model.mem[{sadr, 1'b0}]};
      oc = {u_emda_mem_model.chk[{sadr, 1'b1}], u_emda_mem_model.chk[{sadr, 1'b0}]};
      n = 0;
      while (busy !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
      swr <= 0;
      while (done !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
      if (n >= 40) errors++;
      e = merge(old, sdat, ssel);
      #1 chk("sys word", e, {u_emda_mem_model.mem[{sadr, 1'b1}],
        u_emda_mem_model.mem[{sadr, 1'b0}]});
      chk("sys check", {20'h0, |ssel[3:2] ? exp_check(e[31:16]) : oc[11:6], |ssel[1:0] ? exp_check(e[15:0]) : oc[5:0]},
        {20'h0, u_emda_mem_model.chk[{sadr, 1'b1}], u_emda_mem_model.chk[{sadr, 1'b0}]});
    end
    $display("test system_writes done");
    complete_run;
  end
endmodule // tb_top
